/* File: src/aat_pkg.sv */
// Purpose: shared constants for the alarm threshold and light-sleep block
// Assumes: apb slave, 32-bit data, byte offsets as printed
// Notes: reset values and layouts used by the design and the bench
package aat_pkg;
	localparam logic [7:0] ADDR_HIGH_TH = 8'h24;
	localparam logic [7:0] ADDR_LOW_TH = 8'h28;
	localparam logic [7:0] ADDR_PWR_CTL = 8'h04;
	localparam logic [7:0] ADDR_UNLOCK = 8'h05;
	localparam logic [7:0] ADDR_RESULT = 8'h30;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
	localparam logic [7:0] UNLOCK_KEY = 8'h69;
	localparam logic [7:0] HYST_RESET = 8'h00;
	localparam logic [15:0] UPPER_RESET = 16'hffff;
	localparam logic [15:0] LOWER_RESET = 16'h0000;
	localparam int PWR_SLEEP_BIT = 0;
	localparam int IRQ_HIGH_BIT = 0;
	localparam int IRQ_LOW_BIT = 1;
	localparam int IRQ_WAKE_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	typedef enum logic [1:0] {PS_NORMAL, PS_CONVERT, PS_SLEEP} aat_pstate_t;
endpackage

/* File: src/aat_alarm_sleep.sv */
// Purpose: input alarm thresholds with hysteresis and light-sleep control
// Assumes: apb slave, one clock, inputs synchronous to pclk
// Notes: conversion results arrive on a strobe with an end-of-conversion pulse
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
// Behaviour
// (R1) hysteresis in high register top byte bits
// (R2) host writes fixed low hysteresis bits
// (R3) high register bits 23-16 read zero
// (R4) high compare uses upper limit bits 15:4
// (R5) host writes zero upper limit nibble
// (R6) low compare uses lower limit bits 15:4
// (R7) host writes zero lower limit nibble
// (R8) low register upper half reads zero
// (R9) registers are little-endian byte addressed words
// (R10) power control accepts changes only after key
// (R11) host sets sleep enable after unlocking
// (R12) sleep at conversion end while select high
// (R13) select falling edge wakes from sleep
// (R14) host waits wake time before start
// (R15) normal mode keeps blocks powered
// (R16) overall alarm ORs tripped alarm flags
// (R17) alarms clear with hysteresis beyond limit
module aat_alarm_sleep
	import aat_pkg::*;
#(
	parameter int RES_W = 12
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic convert_start_select,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	output logic light_sleep,
	output logic alarm_high,
	output logic alarm_low,
	output logic overall_alarm_flag,
	output logic irq
);
	import aat_pkg::*;

	// apply byte strobes to a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	logic [7:0] hyst_q, hyst_d;
	logic [15:0] upper_q, upper_d;
	logic [15:0] lower_q, lower_d;
	logic unlocked_q, unlocked_d;
	logic sleep_en_q, sleep_en_d;
	aat_pstate_t ps_q, ps_d;
	logic css_q;
	logic ah_q, ah_d, al_q, al_d;
	logic [RES_W-1:0] res_q;
	logic [2:0] stat_q, stat_d, mask_q;
	logic [31:0] rdata_d;
	logic pready_q, irq_q, ovw_q, sleep_q;

	// apb decode
	wire setup_ok = psel && !penable;
	wire acc = psel && penable && pready_q;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire hit_high = paddr == ADDR_HIGH_TH;
	wire hit_low = paddr == ADDR_LOW_TH;
	wire hit_pwr = paddr == ADDR_PWR_CTL;
	// unlock byte is a lane of an aligned word, never a word address of its own
	wire hit_unl = paddr == {ADDR_UNLOCK[7:2], 2'b00};
	wire hit_res = paddr == ADDR_RESULT;
	wire hit_stat = paddr == ADDR_IRQ_STAT;
	wire hit_mask = paddr == ADDR_IRQ_MASK;
	wire mapped = hit_high | hit_low | hit_pwr | hit_unl | hit_res | hit_stat | hit_mask;
	// (R9) byte lanes follow the little-endian byte addresses
	wire [31:0] hi_new = merge({hyst_q, 8'h00, upper_q}, pwdata, pstrb);
	wire [31:0] lo_new = merge({16'h0000, lower_q}, pwdata, pstrb);
	// key byte sits in lane 1 of the word at 0x04
	wire key_ok = hit_unl && pstrb[ADDR_UNLOCK[1:0]]
		&& pwdata[8*ADDR_UNLOCK[1:0] +: 8] == UNLOCK_KEY;

	// thresholds: only the 12 top bits of each limit count
	// (R4) upper compare bits
	wire [RES_W-1:0] up_lim = upper_q[15:4];
	// (R6) lower compare bits
	wire [RES_W-1:0] lo_lim = lower_q[15:4];
	// (R1) hysteresis from the two top bits
	wire [1:0] hyst = hyst_q[7:6];
	wire [RES_W:0] up_clr = {1'b0, up_lim} - {{(RES_W-1){1'b0}}, hyst};
	wire [RES_W:0] lo_clr = {1'b0, lo_lim} + {{(RES_W-1){1'b0}}, hyst};

	// next-state for registers
	always_comb
	begin
		hyst_d = hyst_q;
		upper_d = upper_q;
		lower_d = lower_q;
		unlocked_d = unlocked_q;
		sleep_en_d = sleep_en_q;
		if (wr && hit_high)
		begin
			hyst_d = hi_new[31:24];
			upper_d = hi_new[15:0];
		end
		if (wr && hit_low)
			lower_d = lo_new[15:0];
		if (wr && key_ok)
			unlocked_d = 1'b1;
		// (R10) power control changes only once unlocked
		if (wr && hit_pwr && unlocked_q && pstrb[0])
		begin
			sleep_en_d = pwdata[PWR_SLEEP_BIT];
			unlocked_d = 1'b0;
		end
	end

	// alarm comparison with hysteresis
	always_comb
	begin
		ah_d = ah_q;
		al_d = al_q;
		if (conv_done)
		begin
			// (R17) set above limit, clear once back by hysteresis
			if (conv_result > up_lim)
				ah_d = 1'b1;
			// an underflowed clear level can never be reached, so no clear then
			else if (!up_clr[RES_W] && {1'b0, conv_result} < up_clr)
				ah_d = 1'b0;
			if (conv_result < lo_lim)
				al_d = 1'b1;
			else if ({1'b0, conv_result} > lo_clr)
				al_d = 1'b0;
		end
	end

	// light-sleep state machine
	always_comb
	begin
		ps_d = ps_q;
		case (ps_q)
			PS_NORMAL:
				if (convert_start_select && !css_q)
					ps_d = PS_CONVERT;
			PS_CONVERT:
				// (R12) enter sleep at conversion end with select high
				if (conv_done)
					ps_d = (sleep_en_q && convert_start_select) ? PS_SLEEP : PS_NORMAL;
			PS_SLEEP:
				// (R13) falling select edge wakes the device
				if (!convert_start_select)
					ps_d = PS_NORMAL;
			default:
				ps_d = PS_NORMAL;
		endcase
	end

	// sticky events; read of status clears, new event wins
	always_comb
	begin
		stat_d = (rd && hit_stat) ? 3'h0 : stat_q;
		if (ah_d && !ah_q)
			stat_d[IRQ_HIGH_BIT] = 1'b1;
		if (al_d && !al_q)
			stat_d[IRQ_LOW_BIT] = 1'b1;
		if (ps_q == PS_SLEEP && ps_d == PS_NORMAL)
			stat_d[IRQ_WAKE_BIT] = 1'b1;
	end

	// read mux: reserved fields read zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		// (R3) bits 23-16 return zero
		if (hit_high)
			rdata_d = {hyst_q, 8'h00, upper_q};
		// (R8) upper half returns zero
		if (hit_low)
			rdata_d = {16'h0000, lower_q};
		if (hit_pwr)
			rdata_d = {30'h0, unlocked_q, sleep_en_q};
		if (hit_res)
			rdata_d = {{(32-RES_W){1'b0}}, res_q};
		if (hit_stat)
			rdata_d = {29'h0, stat_q};
		if (hit_mask)
			rdata_d = {29'h0, mask_q};
	end

	// register state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hyst_q <= HYST_RESET;
			upper_q <= UPPER_RESET;
			lower_q <= LOWER_RESET;
			unlocked_q <= 1'b0;
			sleep_en_q <= 1'b0;
			mask_q <= IRQ_MASK_RESET;
			stat_q <= 3'h0;
		end
		else if (clk_en)
		begin
			hyst_q <= hyst_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			unlocked_q <= unlocked_d;
			sleep_en_q <= sleep_en_d;
			stat_q <= stat_d;
			if (wr && hit_mask && pstrb[0])
				mask_q <= pwdata[2:0];
		end
	end

	// apb answer: ready one cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready_q <= setup_ok;
			pslverr <= setup_ok && !mapped;
			if (setup_ok)
				prdata <= pwrite ? 32'h0000_0000 : rdata_d;
		end
	end
	assign pready = pready_q;

	// converter state and alarms
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ps_q <= PS_NORMAL;
			css_q <= 1'b0;
			ah_q <= 1'b0;
			al_q <= 1'b0;
			res_q <= '0;
			ovw_q <= 1'b0;
			irq_q <= 1'b0;
			sleep_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ps_q <= ps_d;
			sleep_q <= (ps_d == PS_SLEEP);
			css_q <= convert_start_select;
			ah_q <= ah_d;
			al_q <= al_d;
			if (conv_done)
				res_q <= conv_result;
			// (R16) overall flag is the OR of trips
			ovw_q <= ah_d | al_d;
			irq_q <= |(stat_d & mask_q);
		end
	end
	// (R15) powered unless in the sleep state
	assign light_sleep = sleep_q;
	assign alarm_high = ah_q;
	assign alarm_low = al_q;
	assign overall_alarm_flag = ovw_q;
	assign irq = irq_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lock_gate_a: assert property (clk_en && wr && hit_pwr && !unlocked_q |=> // (R10)
		$stable(sleep_en_q)) else $error("power control changed while locked");
	sleep_entry_a: assert property (clk_en && ps_q == PS_CONVERT && conv_done && // (R12)
		sleep_en_q && convert_start_select |=> light_sleep) else $error("no sleep entry");
	sleep_wake_a: assert property (clk_en && light_sleep && !convert_start_select // (R13)
		|=> !light_sleep) else $error("no wake on select low");
	sleep_off_a: assert property (!sleep_en_q && !light_sleep |=> !light_sleep) // (R15)
		else $error("sleep without enable");
	high_trip_a: assert property (clk_en && conv_done && conv_result > up_lim // (R4)
		|=> alarm_high) else $error("high alarm missed");
	low_trip_a: assert property (clk_en && conv_done && conv_result < lo_lim // (R6)
		|=> alarm_low) else $error("low alarm missed");
	ovw_or_a: assert property (overall_alarm_flag == (alarm_high | alarm_low)) // (R16)
		else $error("overall flag mismatch");
	rsvd_high_a: assert property (setup_ok && clk_en && !pwrite && hit_high // (R3)
		|=> prdata[23:16] == 8'h00) else $error("reserved high bits not zero");
	rsvd_low_a: assert property (setup_ok && clk_en && !pwrite && hit_low // (R8)
		|=> prdata[31:16] == 16'h0000) else $error("low register top half not zero");
	hyst_store_a: assert property (clk_en && wr && hit_high && pstrb[3] // (R1)
		|=> hyst_q == $past(pwdata[31:24])) else $error("hysteresis not stored");
	sleep_cov: cover property (ps_q == PS_CONVERT ##1 light_sleep);
	wake_cov: cover property (light_sleep ##1 !light_sleep);
	trip_cov: cover property (!overall_alarm_flag ##1 overall_alarm_flag);
	irq_cov: cover property (irq);
endmodule

/* File: test/aat_host_model.sv */
// Purpose: host side that drives convert start and returns results
// Assumes: one clock, result valid only with the end pulse
// Notes: select parks high while stay is held after the result
`timescale 1ns/1ns
module aat_host_model #(
	parameter int WAKE = 4
)(
	input wire logic pclk,
	input wire logic go,
	input wire logic stay,
	input wire logic [11:0] value,
	output logic convert_start_select = 1'b0,
	output logic conv_done = 1'b0,
	output logic [11:0] conv_result = 12'h000,
	output logic busy
);
	int cnt = 0;
	assign busy = (cnt != 0);
	always @(posedge pclk)
	begin
		conv_done <= 1'b0;
		conv_result <= ~conv_result; // no stale result between pulses
		if (cnt == 0 && go)
		begin
			convert_start_select <= 1'b1;
			cnt <= 1;
		end
		else if (cnt == 4)
		begin
			conv_done <= 1'b1;
			conv_result <= value;
			cnt <= 5;
		end
		else if (cnt == 5)
		begin
			if (!stay)
			begin
				convert_start_select <= 1'b0;
				cnt <= 6;
			end
		end
		else if (cnt >= 6 + WAKE)
			cnt <= 0;
		else if (cnt != 0)
			cnt <= cnt + 1;
	end
endmodule

/* File: test/test_adc_alarm_threshold_and_nap.sv */
// Purpose: self-checking bench for alarm thresholds and light sleep
// Assumes: apb master waits for pready, one clock
// Notes: alarm model with hysteresis is kept in plain bench variables
`timescale 1ns/1ns
module test_adc_alarm_threshold_and_nap;
	import aat_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, stay = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, x = 72646;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, e, css, done, ls, ah, al, ov, irq, busy, mh = 0, ml = 0;
	logic [11:0] res, val = 12'h000;
	int num_errors = 0, comparisons = 0, up = 'ha5, lo = 'h34, hy = 2;
	logic [11:0] seq [5] = '{12'h0a4, 12'h0a2, 12'h033, 12'h035, 12'h037};
	always #4 pclk = ~pclk;
	aat_alarm_sleep dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .convert_start_select(css),
		.conv_done(done), .conv_result(res), .light_sleep(ls), .alarm_high(ah),
		.alarm_low(al), .overall_alarm_flag(ov), .irq(irq));
	aat_host_model host (.pclk(pclk), .go(go), .stay(stay), .value(val),
		.convert_start_select(css), .conv_done(done), .conv_result(res), .busy(busy));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] w);
		comparisons++;
		if (g !== w)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, w);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		// pready is looked at on the rising edge, where the slave samples too
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			stop_test;
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] w);
		apb(0, a, 32'h0, 4'hf);
		chk(q, w);
	endtask
	task conv(input logic [11:0] v, input logic st);
		do
			@(negedge pclk);
		while (busy !== 1'b0);
		@(posedge pclk);
		val <= v;
		stay <= st;
		go <= 1;
		@(posedge pclk);
		go <= 0;
		do
			@(negedge pclk);
		while (done !== 1'b1);
		repeat (2) @(negedge pclk);
		if (v > up)
			mh = 1;
		else if (v < up - hy)
			mh = 0;
		if (v < lo)
			ml = 1;
		else if (v > lo + hy)
			ml = 0;
		chk({29'h0, ah, al, ov}, {29'h0, mh, ml, mh | ml});
	endtask
	task stop_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#300000;
		num_errors++;
		stop_test;
	end
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd(ADDR_HIGH_TH, 32'h0000ffff);
		rd(ADDR_LOW_TH, 32'h0);
		apb(1, ADDR_HIGH_TH, 32'h80ff0a50, 4'hf);
		rd(ADDR_HIGH_TH, 32'h80000a50);
		apb(1, ADDR_LOW_TH, 32'hffff0320, 4'hf);
		apb(1, ADDR_LOW_TH, 32'h00000040, 4'h1);
		rd(ADDR_LOW_TH, 32'h00000340);
		rd(8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		conv(12'h060, 1);
		chk({31'h0, ls}, 32'h0);
		@(posedge pclk);
		stay <= 0;
		apb(0, ADDR_IRQ_STAT, 32'h0, 4'hf);
		conv(12'h0a6, 0);
		chk({31'h0, irq}, 32'h0);
		apb(1, ADDR_IRQ_MASK, 32'h7, 4'hf);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_IRQ_STAT, 32'h1);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		foreach (seq[i])
			conv(seq[i], 0);
		rd(ADDR_RESULT, 32'h00000037);
		repeat (20) conv(12'(32'h20 + rnd() % 160), 0);
		apb(1, ADDR_PWR_CTL, 32'h1, 4'hf);
		rd(ADDR_PWR_CTL, 32'h0);
		apb(1, ADDR_PWR_CTL, 32'h00006900, 4'h2);
		apb(1, ADDR_PWR_CTL, 32'h1, 4'h1);
		rd(ADDR_PWR_CTL, 32'h1);
		apb(0, ADDR_IRQ_STAT, 32'h0, 4'hf);
		conv(12'h060, 1);
		repeat (5) @(negedge pclk);
		chk({31'h0, ls}, 32'h1);
		@(posedge pclk);
		stay <= 0;
		repeat (3) @(negedge pclk);
		chk({31'h0, ls}, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h4);
		stop_test;
	end
endmodule
